//--- src/fcd_pkg.sv
`default_nettype none
package fcd_pkg;
  // Register map
  localparam logic [7:0]  DBG_CTRL_TWO_OFFSET = 8'hEE;
  localparam logic [31:0] DBG_CTRL_TWO_RESET  = 32'h0000_0000;

  // Field positions
  localparam int SECTOR_MSB     = 30;
  localparam int SECTOR_LSB     = 28;
  localparam int RECIRC_DIS_BIT = 27;
  localparam int LOOP_DIS_BIT   = 26;
  localparam int VD_MSB         = 25;
  localparam int VD_LSB         = 16;
  localparam int VQ_MSB         = 15;
  localparam int VQ_LSB         = 6;
  localparam int MEAS_START_BIT = 5;
  localparam int MEAS_R_BIT     = 4;
  localparam int MEAS_L_BIT     = 3;
  localparam int MEAS_KE_BIT    = 2;
  localparam int MEAS_MECH_BIT  = 1;
  localparam int STORE_SHDW_BIT = 0;

  // Writable bits: everything but the reserved top bit
  localparam logic [31:0] DBG_CTRL_TWO_WMASK = 32'h7FFF_FFFF;

  // Forced voltage code mapping; reference = numerator / VREF_DENOM
  localparam logic [9:0]  VREF_POS_LIMIT = 10'd500;
  localparam logic [9:0]  VREF_NEG_START = 10'd512;
  localparam logic [10:0] VREF_WRAP      = 11'd1024;
  localparam int          VREF_DENOM     = 500;

  // Sector select codes
  localparam logic [2:0]  SECTOR_LAST_A  = 3'h0;
  localparam logic [2:0]  SECTOR_LAST_B  = 3'h7;
endpackage : fcd_pkg
`default_nettype wire

//--- src/fcd_vref_map.sv
`timescale 1ns/1ps
`default_nettype none
// Maps a 10-bit forced voltage code to a signed numerator over VREF_DENOM
module fcd_vref_map
  import fcd_pkg::*;
(
  input  wire logic [9:0]         code_i,
  output logic signed [10:0]      numer_o,
  output logic                    invalid_o
);
  always_comb begin
    if (code_i >= VREF_NEG_START) begin
      // Upper half is a two's complement reading of the code
      numer_o = $signed({1'b0, code_i}) - $signed(VREF_WRAP);
    end else if (code_i > VREF_POS_LIMIT) begin
      // 501..511 is outside the legal set; clamp to full positive scale
      numer_o = $signed({1'b0, VREF_POS_LIMIT});
    end else begin
      numer_o = $signed({1'b0, code_i});
    end
    invalid_o = (code_i > VREF_POS_LIMIT) && (code_i < VREF_NEG_START);
  end
endmodule // fcd_vref_map
`default_nettype wire

//--- src/fcd_debug_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Bits 30-28 pick the recirculation stop sector, 1-6 for sectors one to six and 0 or 7 for the last sector before stop.
// - Bit 27 written zero enables forced recirculation stop and written one disables it.
// - Bit 26 set disables both the current loop and the speed loop, clear keeps them enabled.
// - Bits 25-16 give the forced d-axis reference as code/500 up to 500 and (code-1024)/500 from 512.
// - Bits 15-6 give the forced q-axis reference with the same mapping as the d-axis field.
// - Writing one to bit 5 starts the parameter measurement routine.
// - Bit 4 includes winding resistance in the measurement routine.
// - The register sits at offset EEh and holds all zeros after reset.
// - Bit 3 includes winding inductance in the measurement routine.
// - Bit 2 includes the back-EMF constant in the measurement routine.
// - Bit 1 includes mechanical parameters in the measurement routine.
// - Bit 0 set copies the measured parameters into the shadow configuration registers.
module fcd_debug_ctrl
  import fcd_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  // Register port from the serial target logic
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  input  wire logic [7:0]         reg_addr_i,
  input  wire logic [31:0]        reg_wdata_i,
  output logic [31:0]             reg_rdata_o,
  output logic                    reg_rvalid_o,
  output logic                    reg_hit_o,
  // Control outputs to the motor control engine
  output logic [2:0]              stop_sector_o,
  output logic                    stop_sector_last_o,
  output logic                    recirc_stop_en_o,
  output logic                    loop_disable_o,
  output logic                    current_loop_en_o,
  output logic                    speed_loop_en_o,
  output logic signed [10:0]      d_axis_mod_reference_o,
  output logic signed [10:0]      q_axis_mod_reference_o,
  output logic                    vref_code_invalid_o,
  output logic                    param_measure_start_o,
  output logic                    measure_resistance_en_o,
  output logic                    measure_inductance_en_o,
  output logic                    measure_backemf_const_en_o,
  output logic                    measure_mechanical_en_o,
  output logic                    store_measured_to_shadow_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  // Each output has a flop of its own, so the engine never sees decode glitches
  typedef struct packed {
    logic [31:0]        ctrl;
    logic [31:0]        rdata;
    logic               rvalid;
    logic               hit;
    logic               start;
    logic [2:0]         sector;
    logic               last;
    logic               recirc_en;
    logic               loop_dis;
    logic               cur_en;
    logic               spd_en;
    logic signed [10:0] vd;
    logic signed [10:0] vq;
    logic               invalid;
    logic               meas_r;
    logic               meas_l;
    logic               meas_ke;
    logic               meas_mech;
    logic               shadow;
  } fcd_state_type;

  fcd_state_type state;
  fcd_state_type next_state;

  logic signed [10:0] vd_numer;
  logic signed [10:0] vq_numer;
  logic               vd_bad;
  logic               vq_bad;
  logic               wr_hit;
  logic [31:0]        new_ctrl;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding shared by the write, read and hit paths
  function automatic logic is_ctrl_addr(input logic [7:0] addr);
    return addr == DBG_CTRL_TWO_OFFSET;
  endfunction

  // Both end codes stand for the last sector before the stop condition
  function automatic logic is_last_sector(input logic [2:0] code);
    logic last;
    case (code)
      SECTOR_LAST_A: last = 1'b1;
      SECTOR_LAST_B: last = 1'b1;
      default:       last = 1'b0;
    endcase
    return last;
  endfunction

  // Unmapped offsets read as zero, so a stray read never looks like a hit
  function automatic logic [31:0] read_word(input logic [7:0]  addr,
                                            input logic [31:0] ctrl);
    return is_ctrl_addr(addr) ? ctrl : 32'h0000_0000;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write path; outside the next-state process so that the map instances
  // below do not close a loop through that process
  assign wr_hit   = reg_wr_i && is_ctrl_addr(reg_addr_i);
  // Reserved bit is masked on write so it always reads zero
  assign new_ctrl = wr_hit ? (reg_wdata_i & DBG_CTRL_TWO_WMASK)
                           : state.ctrl;

  ////////////////////////////////////////////////////////////////////////////
  // Voltage code mapping, one instance per axis
  fcd_vref_map u_vd_map (
    .code_i    (new_ctrl[VD_MSB:VD_LSB]),
    .numer_o   (vd_numer),
    .invalid_o (vd_bad)
  );

  fcd_vref_map u_vq_map (
    .code_i    (new_ctrl[VQ_MSB:VQ_LSB]),
    .numer_o   (vq_numer),
    .invalid_o (vq_bad)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_state           = state;
    next_state.ctrl      = new_ctrl;
    // Start is a one-cycle pulse per write of one, not a level
    next_state.start     = wr_hit && reg_wdata_i[MEAS_START_BIT];
    next_state.sector    = new_ctrl[SECTOR_MSB:SECTOR_LSB];
    next_state.last      = is_last_sector(new_ctrl[SECTOR_MSB:SECTOR_LSB]);
    // The field is a disable while the engine takes an enable
    next_state.recirc_en = !new_ctrl[RECIRC_DIS_BIT];
    next_state.loop_dis  = new_ctrl[LOOP_DIS_BIT];
    next_state.cur_en    = !new_ctrl[LOOP_DIS_BIT];
    next_state.spd_en    = !new_ctrl[LOOP_DIS_BIT];
    next_state.meas_r    = new_ctrl[MEAS_R_BIT];
    next_state.meas_l    = new_ctrl[MEAS_L_BIT];
    next_state.meas_ke   = new_ctrl[MEAS_KE_BIT];
    next_state.meas_mech = new_ctrl[MEAS_MECH_BIT];
    next_state.shadow    = new_ctrl[STORE_SHDW_BIT];
    // References only act while the loops are disabled
    if (new_ctrl[LOOP_DIS_BIT]) begin
      next_state.vd = vd_numer;
      next_state.vq = vq_numer;
    end else begin
      next_state.vd = '0;
      next_state.vq = '0;
    end
    // Flag only; illegal codes are the writer's fault and are clamped
    next_state.invalid = vd_bad || vq_bad;
    next_state.rvalid  = reg_rd_i;
    next_state.hit     = (reg_rd_i || reg_wr_i) && is_ctrl_addr(reg_addr_i);
    // A read in the cycle of a write still returns the old word
    if (reg_rd_i) begin
      next_state.rdata = read_word(reg_addr_i, state.ctrl);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state.ctrl      <= DBG_CTRL_TWO_RESET;
      state.rdata     <= 32'h0000_0000;
      state.rvalid    <= 1'b0;
      state.hit       <= 1'b0;
      state.start     <= 1'b0;
      state.sector    <= DBG_CTRL_TWO_RESET[SECTOR_MSB:SECTOR_LSB];
      // The reset sector code is one of the last-sector codes
      state.last      <= 1'b1;
      state.recirc_en <= !DBG_CTRL_TWO_RESET[RECIRC_DIS_BIT];
      state.loop_dis  <= DBG_CTRL_TWO_RESET[LOOP_DIS_BIT];
      state.cur_en    <= !DBG_CTRL_TWO_RESET[LOOP_DIS_BIT];
      state.spd_en    <= !DBG_CTRL_TWO_RESET[LOOP_DIS_BIT];
      state.vd        <= '0;
      state.vq        <= '0;
      state.invalid   <= 1'b0;
      state.meas_r    <= DBG_CTRL_TWO_RESET[MEAS_R_BIT];
      state.meas_l    <= DBG_CTRL_TWO_RESET[MEAS_L_BIT];
      state.meas_ke   <= DBG_CTRL_TWO_RESET[MEAS_KE_BIT];
      state.meas_mech <= DBG_CTRL_TWO_RESET[MEAS_MECH_BIT];
      state.shadow    <= DBG_CTRL_TWO_RESET[STORE_SHDW_BIT];
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from state flops
  always_comb begin
    reg_rdata_o                = state.rdata;
    reg_rvalid_o               = state.rvalid;
    reg_hit_o                  = state.hit;
    // Recirculation stop and loop control
    stop_sector_o              = state.sector;
    stop_sector_last_o         = state.last;
    recirc_stop_en_o           = state.recirc_en;
    loop_disable_o             = state.loop_dis;
    current_loop_en_o          = state.cur_en;
    speed_loop_en_o            = state.spd_en;
    // Forced references, numerators over the fixed denominator
    d_axis_mod_reference_o     = state.vd;
    q_axis_mod_reference_o     = state.vq;
    vref_code_invalid_o        = state.invalid;
    // Measurement routine
    param_measure_start_o      = state.start;
    measure_resistance_en_o    = state.meas_r;
    measure_inductance_en_o    = state.meas_l;
    measure_backemf_const_en_o = state.meas_ke;
    measure_mechanical_en_o    = state.meas_mech;
    store_measured_to_shadow_o = state.shadow;
  end

endmodule // fcd_debug_ctrl
`default_nettype wire

//--- verification/fcd_debug_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module fcd_debug_ctrl_assertions (
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        reg_rvalid_o,
  input wire logic [2:0]  stop_sector_o,
  input wire logic        stop_sector_last_o,
  input wire logic        recirc_stop_en_o,
  input wire logic        loop_disable_o,
  input wire logic        current_loop_en_o,
  input wire logic        speed_loop_en_o,
  input wire logic        param_measure_start_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence wr_ee_s;
    reg_wr_i && reg_addr_i == 8'hEE;
  endsequence
  start_pulse_a: assert property (wr_ee_s ##0 reg_wdata_i[5] |=> param_measure_start_o)
    else $error("start pulse missing");
  start_cause_a: assert property (param_measure_start_o |->
    $past(reg_wr_i && reg_addr_i == 8'hEE && reg_wdata_i[5])) else $error("stray start");
  loop_ctrl_a: assert property (wr_ee_s |=> loop_disable_o == $past(reg_wdata_i[26]) &&
    current_loop_en_o == !loop_disable_o && speed_loop_en_o == !loop_disable_o)
    else $error("loop control wrong");
  recirc_pol_a: assert property (wr_ee_s |=> recirc_stop_en_o == !$past(reg_wdata_i[27]))
    else $error("recirc polarity wrong");
  sector_val_a: assert property (wr_ee_s |=> stop_sector_o == $past(reg_wdata_i[30:28]))
    else $error("sector wrong");
  sector_last_a: assert property (stop_sector_last_o == (stop_sector_o inside {3'h0, 3'h7}))
    else $error("last sector flag wrong");
  read_valid_a: assert property (reg_rd_i |=> reg_rvalid_o) else $error("no read answer");
  top_bit_a: assert property (reg_rvalid_o |-> !reg_rdata_o[31]) else $error("top bit set");
  // Other offsets must leave the sector, recirculation and loop-disable controls untouched
  other_addr_a: assert property (reg_wr_i && reg_addr_i != 8'hEE |=>
    $stable({stop_sector_o, recirc_stop_en_o, loop_disable_o})) else $error("foreign write");
endmodule // fcd_debug_ctrl_assertions
bind fcd_debug_ctrl fcd_debug_ctrl_assertions u_chk (
  .clk_i                 (clk_i),
  .rst_b_i               (rst_b_i),
  .reg_wr_i              (reg_wr_i),
  .reg_rd_i              (reg_rd_i),
  .reg_addr_i            (reg_addr_i),
  .reg_wdata_i           (reg_wdata_i),
  .reg_rdata_o           (reg_rdata_o),
  .reg_rvalid_o          (reg_rvalid_o),
  .stop_sector_o         (stop_sector_o),
  .stop_sector_last_o    (stop_sector_last_o),
  .recirc_stop_en_o      (recirc_stop_en_o),
  .loop_disable_o        (loop_disable_o),
  .current_loop_en_o     (current_loop_en_o),
  .speed_loop_en_o       (speed_loop_en_o),
  .param_measure_start_o (param_measure_start_o)
);
`default_nettype wire

//--- verification/fcd_debug_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fcd_debug_ctrl_tb;
  logic clk_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000, reg_rdata_o;
  logic [2:0] stop_sector_o;
  logic signed [10:0] d_axis_mod_reference_o, q_axis_mod_reference_o;
  logic reg_rvalid_o, reg_hit_o, stop_sector_last_o, recirc_stop_en_o, loop_disable_o;
  logic current_loop_en_o, speed_loop_en_o, vref_code_invalid_o, param_measure_start_o;
  logic measure_resistance_en_o, measure_inductance_en_o, measure_backemf_const_en_o;
  logic measure_mechanical_en_o, store_measured_to_shadow_o;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int vc[6] = '{500, 512, 1000, 0, 1, 513};
  int ve[6] = '{500, -512, -24, 0, 1, -511};
  fcd_debug_ctrl DUT (.*);
  initial forever #2 clk_i = ~clk_i;
  // Generous ceiling: the whole run needs well under 200 cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    #1 reg_wr_i = 1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(posedge clk_i);
    #1 reg_wr_i = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    #1 reg_rd_i = 1;
    reg_addr_i = a;
    @(posedge clk_i);
    #1 reg_rd_i = 0;
    chk("rvalid", reg_rvalid_o, 1);
    chk("hit", reg_hit_o, a == 8'hEE);
    chk("rdata", reg_rdata_o, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_sector;
    for (int i = 0; i < 8; i++) begin
      wr(8'hEE, 32'(i) << 28);
      chk("sector", {stop_sector_o, stop_sector_last_o}, {i[2:0], i == 0 || i == 7});
    end
    $display("sector test done");
  endtask
  task automatic t_volt;
    // Only valid codes are written here; 501..511 are off limits for software
    for (int i = 0; i < 6; i += 2) begin
      wr(8'hEE, 32'h0C00_0000 | 32'(vc[i]) << 16 | 32'(vc[i+1]) << 6);
      chk("recirc", recirc_stop_en_o, 0);
      chk("loops", {loop_disable_o, current_loop_en_o, speed_loop_en_o}, 3'b100);
      chk("vd", d_axis_mod_reference_o, ve[i]);
      chk("vq", q_axis_mod_reference_o, ve[i+1]);
      chk("invalid", vref_code_invalid_o, 0);
    end
    wr(8'hEE, 32'(vc[0]) << 16);
    chk("loops on", {recirc_stop_en_o, current_loop_en_o, speed_loop_en_o}, 3'b111);
    chk("refs off", {d_axis_mod_reference_o, q_axis_mod_reference_o}, 0);
    rd(8'hEE, 32'(vc[0]) << 16);
    $display("voltage test done");
  endtask
  task automatic t_meas;
    for (int b = 0; b < 6; b++) begin
      wr(8'hEE, 32'h1 << b);
      chk("start", param_measure_start_o, b == 5);
      chk("meas", {measure_resistance_en_o, measure_inductance_en_o, measure_backemf_const_en_o,
        measure_mechanical_en_o, store_measured_to_shadow_o}, 5'(32'h1 << b));
      @(posedge clk_i);
      #1 chk("start end", param_measure_start_o, 0);
    end
    $display("measure test done");
  endtask
  task automatic t_odd;
    wr(8'hEE, 32'h8000_0000);
    rd(8'hEE, 32'h0000_0000);
    wr(8'hEE, 32'h0400_0000);
    wr(8'hEF, 32'h0000_0000);
    chk("foreign", loop_disable_o, 1);
    rd(8'hEF, 32'h0000_0000);
    $display("reserved test done");
  endtask
  task automatic t_reset(input bit mid);
    if (mid) begin
      // Every field but the two voltage codes set to a nonzero legal code, so the reset has something to clear
      wr(8'hEE, 32'h7C00_003F);
      chk("preset", {loop_disable_o, param_measure_start_o}, 2'b11);
      rst_b_i = 0;
    end
    repeat (3) @(posedge clk_i);
    #1 rst_b_i = 1;
    chk("reset ctl", {recirc_stop_en_o, current_loop_en_o, speed_loop_en_o,
      stop_sector_last_o, loop_disable_o}, 5'h1E);
    chk("reset sector", stop_sector_o, 3'h0);
    chk("reset vd", d_axis_mod_reference_o, 0);
    chk("reset vq", q_axis_mod_reference_o, 0);
    chk("reset start", param_measure_start_o, 0);
    chk("reset meas", {measure_resistance_en_o, measure_inductance_en_o, measure_backemf_const_en_o,
      measure_mechanical_en_o, store_measured_to_shadow_o, vref_code_invalid_o}, 6'h00);
    rd(8'hEE, 32'h0000_0000);
    $display("reset test done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    t_reset(1'b0);
    t_sector();
    t_volt();
    t_meas();
    t_odd();
    t_reset(1'b1);
    report_and_stop();
  end
endmodule // fcd_debug_ctrl_tb
`default_nettype wire
